// ### rtl/ebp_map.svh
// register offsets, field positions, reset values and counts of the emulator break port
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH
`define EBP_OFF_CTRL 12'h000
`define EBP_OFF_STATUS 12'h004
`define EBP_OFF_BREAK 12'h008
`define EBP_OFF_MEMCHK 12'h00c
`define EBP_OFF_PORTIN 12'h010
`define EBP_OFF_CLKCFG 12'h014
`define EBP_CTRL_RUN 0
`define EBP_CTRL_FORCE 1
`define EBP_CTRL_STEP 2
`define EBP_CTRL_RESET 3
`define EBP_BREAK_EN 31
`define EBP_BREAK_MASK 32'h8000_07ff
`define EBP_MEMCHK_MASK 32'h0fff_00ff
`define EBP_MEMCHK_RAM_OK 30
`define EBP_MEMCHK_ROM_OK 31
`define EBP_CLKCFG_MASK 32'h0000_0001
`define EBP_CLKCFG_RESET 32'h0000_0001
`define EBP_RAM_GROUP_WORDS 4'hc
`define EBP_ROM_WORDS_SMALL 12'h400
`define EBP_ROM_WORDS_LARGE 12'h800
`define EBP_XIN_DIV_MAX 3'h7
`define EBP_CORE_RST_CYC 3'h4
`define EBP_RESP_OKAY 2'h0
`define EBP_RESP_SLVERR 2'h2
`endif

// ### rtl/ebp_pkg.sv
// types shared by the emulator break port files
package ebp_pkg;
  typedef enum logic [3:0] {
    EBP_T1 = 4'h1,
    EBP_T2 = 4'h2,
    EBP_T3 = 4'h4,
    EBP_T4 = 4'h8
  } ebp_tstate_e;
  typedef enum logic [2:0] {
    EBP_HALT = 3'h1,
    EBP_RUN = 3'h2,
    EBP_PDOWN = 3'h4
  } ebp_mode_e;
endpackage

// ### rtl/ebp_tstate.sv
// instruction clock divider and four-state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ebp_map.svh"
module ebp_tstate (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_tick,
  input wire logic div8_sel,
  output logic tick_q,
  output var ebp_pkg::ebp_tstate_e state_q
);
  import ebp_pkg::*;
  logic [2:0] div_q;
  ebp_tstate_e state_d;
  wire adv = osc_tick & (!div8_sel | (div_q == `EBP_XIN_DIV_MAX));
  wire [2:0] div_d = !osc_tick ? div_q : (adv ? 3'h0 : div_q + 3'h1);

  // one state per instruction clock, T1 to T4 and round again
  always_comb begin
    unique case (state_q)
      EBP_T1: state_d = EBP_T2;
      EBP_T2: state_d = EBP_T3;
      EBP_T3: state_d = EBP_T4;
      EBP_T4: state_d = EBP_T1;
      default: state_d = EBP_T1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 3'h0;
      tick_q <= 1'b0;
      state_q <= EBP_T4;
    end else begin
      div_q <= div_d;
      tick_q <= adv;
      if (adv) begin
        state_q <= state_d;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/ebp_top.sv
// emulator break port: break control, memory areas, port timing, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "ebp_map.svh"
module ebp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_tick,
  input wire logic memory_size_switch_low,
  input wire logic memory_size_switch_high,
  input wire logic ext_trig,
  input wire logic key_on_wakeup,
  input wire logic core_fetch_valid,
  input wire logic [10:0] core_fetch_addr,
  input wire logic core_instr_cont,
  input wire logic core_instr_skipped,
  input wire logic core_instr_watchdog_restart_instr,
  input wire logic core_instr_pof,
  input wire logic core_instr_out,
  input wire logic [7:0] core_out_d,
  input wire logic [2:0] core_out_e,
  input wire logic [3:0] core_out_g,
  input wire logic core_out_carrier_output,
  input wire logic [7:0] port_d_in,
  input wire logic [2:0] port_e_in,
  input wire logic [3:0] port_g_in,
  input wire logic [8:0] pulldown_switch,
  output logic core_run_q,
  output logic core_reset_q,
  output logic core_timer_en_q,
  output logic core_wdt_en_q,
  output logic instruction_clock_tick,
  output var ebp_pkg::ebp_tstate_e instruction_clock_state,
  output logic [7:0] port_d_q,
  output logic port_e0_q,
  output logic [3:0] port_g_q,
  output logic aux_port_bit_one_q,
  output logic aux_port_bit_two_q,
  output logic carrier_output_q,
  output logic check_test_point_q,
  output logic [14:0] port_in_q,
  output logic [8:0] pulldown_en_q
);
  import ebp_pkg::*;

  ebp_mode_e mode_q, mode_d;
  logic aw_rdy_q, ar_rdy_q;
  logic [31:0] break_q, memchk_q, clkcfg_q;
  logic hw_pend_q, force_pend_q, step_q, step_arm_q, resume_q, ext_q;
  logic [2:0] cause_q, rst_cnt_q;
  logic out_cur_q, staged_vld_q;
  logic [15:0] out_img_q, staged_q;

  ebp_tstate u_tstate (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_tick(osc_tick),
    .div8_sel(clkcfg_q[0]),
    .tick_q(instruction_clock_tick),
    .state_q(instruction_clock_state)
  );

  // bus decode
  wire wr_take = aw_rdy_q & s_axi_awvalid & s_axi_wvalid;
  wire rd_take = ar_rdy_q & s_axi_arvalid;
  wire [11:0] wa = {s_axi_awaddr[11:2], 2'h0};
  wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd = s_axi_wdata & wmask;
  wire sel_ctrl = wa == `EBP_OFF_CTRL;
  wire sel_break = wa == `EBP_OFF_BREAK;
  wire sel_memchk = wa == `EBP_OFF_MEMCHK;
  wire sel_clkcfg = wa == `EBP_OFF_CLKCFG;
  wire wr_known = sel_ctrl | sel_break | sel_memchk | sel_clkcfg | (wa == `EBP_OFF_STATUS)
                  | (wa == `EBP_OFF_PORTIN);
  // no debug command gets through in power-down
  wire wr_refused = (mode_q == EBP_PDOWN) & (sel_ctrl | sel_break | sel_memchk | sel_clkcfg);
  wire wr_ok = wr_take & !wr_refused;
  wire cmd_run = wr_ok & sel_ctrl & wd[`EBP_CTRL_RUN];
  wire cmd_force = wr_ok & sel_ctrl & wd[`EBP_CTRL_FORCE];
  wire cmd_step = wr_ok & sel_ctrl & wd[`EBP_CTRL_STEP];
  wire cmd_reset = wr_ok & sel_ctrl & wd[`EBP_CTRL_RESET];

  // memory area check against the size switches
  wire cfg48 = memory_size_switch_high & !memory_size_switch_low;
  wire cfg64 = memory_size_switch_high & memory_size_switch_low;
  wire [7:0] chk_ram = memchk_q[7:0];
  wire [11:0] chk_rom = memchk_q[27:16];
  wire ram_ok48 = cfg48 & (chk_ram[7:6] == 2'h0) & (chk_ram[3:0] < `EBP_RAM_GROUP_WORDS);
  wire ram_ok = ram_ok48 | (cfg64 & (chk_ram[7:6] == 2'h0));
  wire rom_ok = (cfg48 & (chk_rom < `EBP_ROM_WORDS_SMALL))
                | (cfg64 & (chk_rom < `EBP_ROM_WORDS_LARGE));

  // break decisions, taken at each fetch while running
  wire t1 = instruction_clock_tick & (instruction_clock_state == EBP_T1);
  wire t2 = instruction_clock_tick & (instruction_clock_state == EBP_T2);
  wire t3 = instruction_clock_tick & (instruction_clock_state == EBP_T3);
  wire t4 = instruction_clock_tick & (instruction_clock_state == EBP_T4);
  wire running = mode_q == EBP_RUN;
  wire fetch_ok = core_fetch_valid & running;
  // the first fetch after a resume is the halted instruction itself, or the one just after the continuous run it halted in
  wire bp_hit = break_q[`EBP_BREAK_EN] & (core_fetch_addr == break_q[10:0])
                & !core_instr_skipped & !resume_q;
  wire hw_go = (bp_hit | hw_pend_q) & !core_instr_cont;
  wire halt_now = fetch_ok & (hw_go | force_pend_q | step_arm_q);
  wire exec_ok = fetch_ok & !halt_now;
  wire ext_rise = ext_trig & !ext_q;
  wire force_set = running & (cmd_force | ext_rise);

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      EBP_HALT: if (cmd_run | cmd_step) begin
        mode_d = EBP_RUN;
      end
      EBP_RUN: if (halt_now | cmd_reset) begin
        mode_d = EBP_HALT;
      end else if (exec_ok & core_instr_pof) begin
        mode_d = EBP_PDOWN;
      end
      EBP_PDOWN: if (key_on_wakeup) begin
        mode_d = EBP_RUN;
      end
      default: mode_d = EBP_HALT;
    endcase
  end

  wire [2:0] rst_cnt_d = cmd_reset ? `EBP_CORE_RST_CYC
                         : (rst_cnt_q != 3'h0) ? rst_cnt_q - 3'h1 : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= EBP_HALT;
      core_run_q <= 1'b0;
      rst_cnt_q <= 3'h0;
      core_reset_q <= 1'b0;
      core_timer_en_q <= 1'b0;
      core_wdt_en_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      core_run_q <= mode_d == EBP_RUN;
      rst_cnt_q <= rst_cnt_d;
      core_reset_q <= rst_cnt_d != 3'h0;
      core_timer_en_q <= 1'b1;
      core_wdt_en_q <= 1'b0;
      ext_q <= ext_trig;
    end
  end

  // pending breaks; a new forced request wins over the clear in the same cycle, a new hardware request loses to it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_pend_q <= 1'b0;
      force_pend_q <= 1'b0;
      step_q <= 1'b0;
      step_arm_q <= 1'b0;
      resume_q <= 1'b0;
      cause_q <= 3'h0;
    end else begin
      hw_pend_q <= !halt_now & !cmd_reset & (hw_pend_q | (fetch_ok & bp_hit & core_instr_cont));
      force_pend_q <= force_set | (force_pend_q & !halt_now & !cmd_reset);
      if (cmd_run | cmd_step | cmd_reset) begin
        step_q <= cmd_step & !cmd_reset;
        step_arm_q <= 1'b0;
        resume_q <= !cmd_reset;
      end else if (fetch_ok) begin
        step_q <= 1'b0;
        step_arm_q <= step_q;
        resume_q <= 1'b0;
      end
      if (halt_now) begin
        cause_q <= {step_arm_q, force_pend_q, hw_go};
      end
    end
  end

  // port timing: real-timing bits at T4, emulated ports one output instruction late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_cur_q <= 1'b0;
      out_img_q <= 16'h0000;
      staged_q <= 16'h0000;
      staged_vld_q <= 1'b0;
      port_d_q <= 8'h00;
      port_e0_q <= 1'b0;
      port_g_q <= 4'h0;
      aux_port_bit_one_q <= 1'b0;
      aux_port_bit_two_q <= 1'b0;
      carrier_output_q <= 1'b0;
      check_test_point_q <= 1'b0;
      port_in_q <= 15'h0000;
      pulldown_en_q <= 9'h000;
    end else begin
      if (t1) begin
        out_cur_q <= exec_ok & core_instr_out;
        check_test_point_q <= exec_ok & core_instr_watchdog_restart_instr;
      end
      if (exec_ok & core_instr_out) begin
        out_img_q <= {core_out_carrier_output, core_out_g, core_out_e, core_out_d};
      end
      if (t2 & out_cur_q & staged_vld_q) begin
        port_d_q <= staged_q[7:0];
        port_e0_q <= staged_q[8];
        port_g_q <= staged_q[14:11];
      end
      if (t4 & out_cur_q) begin
        aux_port_bit_one_q <= out_img_q[9];
        aux_port_bit_two_q <= out_img_q[10];
        carrier_output_q <= out_img_q[15];
        staged_q <= out_img_q;
        staged_vld_q <= 1'b1;
      end
      if (t3) begin
        port_in_q <= {port_g_in, port_e_in, port_d_in};
      end
      // pulldowns follow the board switches only
      pulldown_en_q <= pulldown_switch;
    end
  end

  // register file and AXI4-Lite handshakes
  wire [31:0] status_w = {23'h00_0000, core_reset_q, memory_size_switch_high,
                          memory_size_switch_low, cause_q, mode_q};
  wire [31:0] memchk_w = {rom_ok, ram_ok, memchk_q[29:0]};
  wire rd_known = (ra == `EBP_OFF_CTRL) | (ra == `EBP_OFF_STATUS) | (ra == `EBP_OFF_BREAK)
                  | (ra == `EBP_OFF_MEMCHK) | (ra == `EBP_OFF_PORTIN) | (ra == `EBP_OFF_CLKCFG);
  wire [31:0] rd_mux = (ra == `EBP_OFF_STATUS) ? status_w
                       : (ra == `EBP_OFF_BREAK) ? break_q
                       : (ra == `EBP_OFF_MEMCHK) ? memchk_w
                       : (ra == `EBP_OFF_PORTIN) ? {17'h0_0000, port_in_q}
                       : (ra == `EBP_OFF_CLKCFG) ? clkcfg_q : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q <= 1'b0;
      ar_rdy_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EBP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `EBP_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      break_q <= 32'h0000_0000;
      memchk_q <= 32'h0000_0000;
      clkcfg_q <= `EBP_CLKCFG_RESET;
    end else begin
      // address and data are taken together, one write at a time
      aw_rdy_q <= s_axi_awvalid & s_axi_wvalid & !aw_rdy_q & !s_axi_bvalid;
      ar_rdy_q <= s_axi_arvalid & !ar_rdy_q & !s_axi_rvalid;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_known & !wr_refused) ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (wr_ok & sel_break) begin
        break_q <= ((break_q & ~wmask) | wd) & `EBP_BREAK_MASK;
      end
      if (wr_ok & sel_memchk) begin
        memchk_q <= ((memchk_q & ~wmask) | wd) & `EBP_MEMCHK_MASK;
      end
      if (wr_ok & sel_clkcfg) begin
        clkcfg_q <= ((clkcfg_q & ~wmask) | wd) & `EBP_CLKCFG_MASK;
      end
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = aw_rdy_q;
  assign s_axi_arready = ar_rdy_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_by_command: assert property (
    $rose(core_reset_q) |-> $past(cmd_reset) ##1 core_reset_q[*3] ##1 !core_reset_q)
    else $error("core reset not a four cycle pulse from the reset command");
  a_area_small: assert property (
    cfg48 && chk_ram[3:0] >= 4'hc |-> !ram_ok && (rom_ok == (chk_rom < 12'h400)))
    else $error("48 word area check wrong");
  a_area_large: assert property (
    cfg64 |-> ram_ok == (chk_ram < 8'h40) && rom_ok == (chk_rom < 12'h800))
    else $error("64 word area check wrong");
  a_wdt_off: assert property (
    !core_wdt_en_q)
    else $error("watchdog enabled");
  a_watchdog_restart_instr_marker: assert property (
    t1 && exec_ok && core_instr_watchdog_restart_instr |=> check_test_point_q)
    else $error("check test point missed a watchdog restart");
  a_timer_runs: assert property (
    $past(aresetn) && mode_q != EBP_RUN |-> core_timer_en_q)
    else $error("timer stopped while halted");
  a_pdown_refuse: assert property (
    wr_take && sel_ctrl && mode_q == EBP_PDOWN |=> s_axi_bvalid
      && s_axi_bresp == 2'h2 && mode_q == EBP_PDOWN)
    else $error("command accepted in power-down");
  a_run_no_hw_break: assert property (
    fetch_ok && core_instr_cont && !force_pend_q && !step_arm_q |=> mode_q == EBP_RUN || $past(cmd_reset))
    else $error("halted inside a continuous run");
  a_force_halts: assert property (
    fetch_ok && force_pend_q |=> mode_q == EBP_HALT ##1 !core_run_q)
    else $error("forced break did not halt");
  a_skip_no_break: assert property (
    fetch_ok && core_instr_skipped && !hw_pend_q && !force_pend_q && !step_arm_q |=> mode_q != EBP_HALT || $past(cmd_reset))
    else $error("skipped instruction halted");
  a_emu_at_t2: assert property (
    $changed(port_d_q) || $changed(port_g_q) || $changed(port_e0_q) |-> $past(t2))
    else $error("emulated port changed outside T2");
  a_real_at_t4: assert property (
    $changed(carrier_output_q) || $changed(aux_port_bit_one_q)
      || $changed(aux_port_bit_two_q) |-> $past(t4))
    else $error("real-timing port changed outside T4");
  a_input_at_t3: assert property (
    $changed(port_in_q) |-> $past(t3))
    else $error("input sampled outside T3");
  c_hw_break: cover property (fetch_ok && hw_go ##1 mode_q == EBP_HALT);
  c_run_pend: cover property (fetch_ok && bp_hit && core_instr_cont ##[1:40] halt_now);
  c_pdown_wake: cover property (mode_q == EBP_PDOWN ##[1:40] mode_q == EBP_RUN);
  c_emu_update: cover property (t2 && out_cur_q && staged_vld_q);
endmodule
`default_nettype wire

// ### verif/ebp_core_model.sv
// core-side partner model: fetch stream, qualifiers and port images
`timescale 1ns/1ps
`default_nettype none
module ebp_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_run_q,
  input wire logic core_reset_q,
  input wire logic instruction_clock_tick,
  input wire ebp_pkg::ebp_tstate_e instruction_clock_state,
  output logic core_fetch_valid,
  output logic [10:0] core_fetch_addr,
  output logic core_instr_cont,
  output logic core_instr_skipped,
  output logic core_instr_watchdog_restart_instr,
  output logic core_instr_pof,
  output logic core_instr_out,
  output logic [7:0] core_out_d,
  output logic [2:0] core_out_e,
  output logic [3:0] core_out_g,
  output logic core_out_carrier_output,
  output logic [10:0] last_q
);
  import ebp_pkg::*;
  logic [10:0] pc_q;
  logic run_d_q;
  wire [3:0] lo = pc_q[3:0];
  wire in_run = (last_q[3:0] >= 4'h1) && (last_q[3:0] <= 4'h3);
  // one fetch per instruction, in the first cycle of T1
  assign core_fetch_valid = instruction_clock_tick && (instruction_clock_state == EBP_T1)
    && core_run_q;
  assign core_fetch_addr = pc_q;
  assign core_instr_cont = (lo >= 4'h1) && (lo <= 4'h3);
  assign core_instr_skipped = (lo == 4'h6);
  assign core_instr_watchdog_restart_instr = (lo == 4'h8);
  assign core_instr_out = (lo >= 4'h9) && (lo <= 4'hb);
  assign core_instr_pof = (lo == 4'hc);
  assign core_out_d = {lo, ~lo};
  assign core_out_e = lo[2:0];
  assign core_out_g = lo ^ 4'h5;
  assign core_out_carrier_output = lo[0];
  always_ff @(posedge aclk) begin
    run_d_q <= core_run_q;
    if (!aresetn || core_reset_q) begin
      pc_q <= 11'h000;
      last_q <= 11'h000;
    end else if (core_fetch_valid) begin
      pc_q <= pc_q + 11'h001;
      last_q <= pc_q;
    end else if (run_d_q && !core_run_q && last_q[3:0] != 4'hc) begin
      // a halted instruction is fetched again on resume; power-off already ran
      // a halt inside a continuous run restarts just after the run
      pc_q <= in_run ? {last_q[10:4], 4'h4} : last_q;
    end
  end
endmodule
`default_nettype wire

// ### verif/emulator_break_port_emulation_tb.sv
// self-checking bench for the emulator break port
`timescale 1ns/1ps
`default_nettype none
`include "ebp_map.svh"
module emulator_break_port_emulation_tb;
  import ebp_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, core_out_g, port_g_in, port_g_q, ts_prev;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic osc_tick, memory_size_switch_low, memory_size_switch_high, ext_trig, key_on_wakeup;
  logic core_fetch_valid, core_instr_cont, core_instr_skipped, core_instr_watchdog_restart_instr;
  logic core_instr_pof, core_instr_out, core_out_carrier_output, core_run_q, core_reset_q;
  logic core_timer_en_q, core_wdt_en_q, instruction_clock_tick, port_e0_q, tp_seen;
  logic aux_port_bit_one_q, aux_port_bit_two_q, carrier_output_q, check_test_point_q;
  logic [10:0] core_fetch_addr, last_q, a;
  logic [7:0] core_out_d, port_d_in, port_d_q;
  logic [2:0] core_out_e, port_e_in;
  logic [14:0] port_in_q;
  logic [8:0] pulldown_switch, pulldown_en_q;
  logic [23:0] r;
  ebp_tstate_e instruction_clock_state;
  int fail_count = 0;
  int checked = 0;
  int rst_hi = 0;
  // {switch high, switch low, ram addr, rom addr, {rom ok, ram ok}}
  logic [23:0] mtab [0:6] = '{{1'h1, 1'h0, 8'h0b, 12'h3ff, 2'h3},
    {1'h1, 1'h0, 8'h0c, 12'h400, 2'h0}, {1'h1, 1'h0, 8'h3b, 12'h000, 2'h3},
    {1'h1, 1'h0, 8'h40, 12'h3ff, 2'h2}, {1'h1, 1'h1, 8'h3f, 12'h7ff, 2'h3},
    {1'h1, 1'h1, 8'h40, 12'h800, 2'h0}, {1'h0, 1'h1, 8'h00, 12'h000, 2'h0}};

  ebp_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .osc_tick, .memory_size_switch_low, .memory_size_switch_high, .ext_trig,
    .key_on_wakeup, .core_fetch_valid, .core_fetch_addr, .core_instr_cont, .core_instr_skipped,
    .core_instr_watchdog_restart_instr, .core_instr_pof, .core_instr_out, .core_out_d, .core_out_e, .core_out_g,
    .core_out_carrier_output, .port_d_in, .port_e_in, .port_g_in, .pulldown_switch, .core_run_q,
    .core_reset_q, .core_timer_en_q, .core_wdt_en_q, .instruction_clock_tick,
    .instruction_clock_state, .port_d_q, .port_e0_q, .port_g_q, .aux_port_bit_one_q,
    .aux_port_bit_two_q, .carrier_output_q, .check_test_point_q, .port_in_q, .pulldown_en_q);

  ebp_core_model i_core (.aclk, .aresetn, .core_run_q, .core_reset_q, .instruction_clock_tick,
    .instruction_clock_state, .core_fetch_valid, .core_fetch_addr, .core_instr_cont,
    .core_instr_skipped, .core_instr_watchdog_restart_instr, .core_instr_pof, .core_instr_out, .core_out_d,
    .core_out_e, .core_out_g, .core_out_carrier_output, .last_q);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // oscillator pulse every other cycle; time is scaled, limits hold in ratio
  always @(posedge aclk) osc_tick <= ~osc_tick;

  always @(posedge aclk) begin
    if (core_reset_q === 1'b1) rst_hi++;
    if (check_test_point_q === 1'b1) tp_seen = 1'b1;
    if (!aresetn) begin
      ts_prev <= 4'h8;
    end else if (instruction_clock_tick === 1'b1) begin
      if (instruction_clock_state !== {ts_prev[2:0], ts_prev[3]}) err("state order");
      ts_prev <= instruction_clock_state;
    end
  end

  task automatic err(input string m);
    fail_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) err(m);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // address and data are taken by one shared ready
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e, "read data");
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
  endtask

  task automatic wait_halt;
    int n;
    n = 0;
    while (core_run_q !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 100) err("core never started");
    n = 0;
    while (core_run_q !== 1'b0 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) err("core never stopped");
    repeat (2) @(posedge aclk);
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #250_000;
    err("watchdog expired");
    give_verdict();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {osc_tick, ext_trig, key_on_wakeup, memory_size_switch_low, memory_size_switch_high} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    port_d_in = 8'h3c;
    port_e_in = 3'h5;
    port_g_in = 4'h9;
    pulldown_switch = 9'h1a5;
    tp_seen = 1'b0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({28'h0, instruction_clock_state}, 32'h0000_0008, "reset state");
    chk({31'h0, core_wdt_en_q}, 32'h0000_0000, "watchdog enabled");
    chk({31'h0, core_timer_en_q}, 32'h0000_0001, "timer stopped");
    rd(`EBP_OFF_CLKCFG, 32'hffff_ffff, `EBP_CLKCFG_RESET, `EBP_RESP_OKAY);
    rd(12'h020, 32'hffff_ffff, 32'h0000_0000, `EBP_RESP_SLVERR);
    wr(`EBP_OFF_CLKCFG, 32'h0000_0000, `EBP_RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      r = mtab[i];
      @(posedge aclk);
      memory_size_switch_high <= r[23];
      memory_size_switch_low <= r[22];
      wr(`EBP_OFF_MEMCHK, {4'h0, r[13:2], 8'h00, r[21:14]}, `EBP_RESP_OKAY);
      rd(`EBP_OFF_MEMCHK, 32'hc000_0000, {r[1:0], 30'h0}, `EBP_RESP_OKAY);
      rd(`EBP_OFF_STATUS, 32'h0000_00c0, {24'h0, r[23:22], 6'h0}, `EBP_RESP_OKAY);
    end
    wr(`EBP_OFF_BREAK, 32'h8000_0002, `EBP_RESP_OKAY);
    wr(`EBP_OFF_CTRL, 32'h0000_0001, `EBP_RESP_OKAY);
    wait_halt();
    chk({21'h0, last_q}, 32'h0000_0004, "break inside run");
    rd(`EBP_OFF_STATUS, 32'h0000_003f, 32'h0000_0009, `EBP_RESP_OKAY);
    chk({31'h0, core_timer_en_q}, 32'h0000_0001, "timer stopped when halted");
    rst_hi = 0;
    wr(`EBP_OFF_CTRL, 32'h0000_0008, `EBP_RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk(rst_hi, 32'h0000_0004, "reset pulse length");
    wr(`EBP_OFF_BREAK, 32'h8000_0006, `EBP_RESP_OKAY);
    wr(`EBP_OFF_CTRL, 32'h0000_0001, `EBP_RESP_OKAY);
    wait_halt();
    rd(`EBP_OFF_STATUS, 32'h0000_0007, 32'h0000_0004, `EBP_RESP_OKAY);
    chk({24'h0, port_d_q}, 32'h0000_00a5, "port d timing");
    chk({28'h0, port_g_q}, 32'h0000_000f, "port g timing");
    chk({31'h0, port_e0_q}, 32'h0000_0000, "port e0 timing");
    chk({29'h0, aux_port_bit_two_q, aux_port_bit_one_q, carrier_output_q}, 32'h0000_0003,
      "aux and carrier timing");
    chk({31'h0, tp_seen}, 32'h0000_0001, "test point idle");
    wr(`EBP_OFF_CTRL, 32'h0000_0001, `EBP_RESP_SLVERR);
    @(posedge aclk);
    key_on_wakeup <= 1'b1;
    @(posedge aclk);
    key_on_wakeup <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({31'h0, core_run_q}, 32'h0000_0001, "wakeup");
    ext_trig <= 1'b1;
    wait_halt();
    ext_trig <= 1'b0;
    rd(`EBP_OFF_STATUS, 32'h0000_003f, 32'h0000_0011, `EBP_RESP_OKAY);
    rd(`EBP_OFF_PORTIN, 32'h0000_7fff, {17'h0, port_g_in, port_e_in, port_d_in},
      `EBP_RESP_OKAY);
    chk({23'h0, pulldown_en_q}, {23'h0, pulldown_switch}, "pulldown");
    wr(`EBP_OFF_CTRL, 32'h0000_0008, `EBP_RESP_OKAY);
    wr(`EBP_OFF_BREAK, 32'h0000_0000, `EBP_RESP_OKAY);
    wr(`EBP_OFF_CTRL, 32'h0000_0001, `EBP_RESP_OKAY);
    for (int n = 0; n < 200 && last_q !== 11'h001; n++) @(posedge aclk);
    wr(`EBP_OFF_CTRL, 32'h0000_0002, `EBP_RESP_OKAY);
    wait_halt();
    a = last_q;
    chk({31'h0, (a === 11'h002 || a === 11'h003)}, 32'h0000_0001, "forced break in run");
    // stepping starts away from the power-off address
    wr(`EBP_OFF_CTRL, 32'h0000_0004, `EBP_RESP_OKAY);
    wait_halt();
    rd(`EBP_OFF_STATUS, 32'h0000_003f, 32'h0000_0021, `EBP_RESP_OKAY);
    chk({21'h0, last_q}, 32'h0000_0005, "restart after run");
    // one breakpoint only: the host puts it after the skipped instruction
    wr(`EBP_OFF_BREAK, 32'h8000_0007, `EBP_RESP_OKAY);
    wr(`EBP_OFF_CTRL, 32'h0000_0001, `EBP_RESP_OKAY);
    wait_halt();
    chk({21'h0, last_q}, 32'h0000_0007, "break after skip");
    give_verdict();
  end
endmodule
`default_nettype wire
